// *** verilog/rfid_tx_consts.svh ***
/*
 * Constants for the transmit timing and options register block: register
 * indices, reset values, timing steps and bus answers.
 * Assumes it is included by bare name after the package.
 */
`ifndef RFID_TX_CONSTS_SVH
`define RFID_TX_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_PROTO_CTRL 8'h01
`define IDX_HR_OPTIONS 8'h03
`define IDX_PULSE_LEN 8'h06
`define IDX_NO_REPLY 8'h07
`define IDX_IRQ_STATUS 8'h0c
`define IDX_IRQ_MASK 8'h0d
`define IDX_BLOCK_STATE 8'h0e
`define ADDR_LSB 2

`define RST_PROTO_CTRL 8'h00
`define RST_HR_OPTIONS 8'h00
`define RST_PULSE_LEN 8'h00
`define RST_NO_REPLY 8'h0e
`define RST_IRQ 8'h00

`define IRQ_NO_REPLY_BIT 0

// times in picoseconds
`define CLK_PERIOD_PS 40'd8000
`define PULSE_STEP_PS 40'd73700
`define NO_REPLY_STEP_PS 40'd37760000
`define PRESET_PS_106 40'd2360000
`define PRESET_PS_212 40'd1400000
`define PRESET_PS_424 40'd737000
`define PRESET_PS_848 40'd442000

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** verilog/rfid_tx_pkg.sv ***
/*
 * Types for the transmit timing and options register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package rfid_tx_pkg;

    typedef enum logic [1:0] {
        RATE_106,
        RATE_212,
        RATE_424,
        RATE_848
    } tx_rate_e;

    typedef struct packed {
        logic split_rate_enable;
        tx_rate_e tx_rate;
        logic tx_last_byte_even_parity;
        logic rx_last_byte_even_parity;
        logic [2:0] unused;
    } hr_options_s;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } byte_beat_s;

    typedef enum logic {
        NR_IDLE,
        NR_WAIT
    } nr_state_e;

endpackage
`default_nettype wire

// *** verilog/interval_timer.sv ***
/*
 * Interval timer: after start it stays busy until the elapsed time, counted in
 * clock periods, reaches the target given in picoseconds; then one done pulse.
 * Assumes target is nonzero and that stop has priority over expiry.
 */
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
    parameter int TGT_W = 40,
    parameter logic [39:0] PERIOD_PS = 40'd8000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic start,
    input wire logic stop,
    input wire logic [TGT_W-1:0] target_ps,
    output logic busy,
    output logic done
);
    logic [TGT_W-1:0] acc_q;
    logic [TGT_W-1:0] tgt_q;
    logic run_q;
    logic done_q;

    if (TGT_W < 34 || TGT_W > 40) begin : g_chk
        $error("interval_timer: TGT_W must be 34..40");
    end

    // time rounds up: done once the elapsed periods cover the target
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= 1'b0;
            done_q <= 1'b0;
            acc_q <= '0;
            tgt_q <= '0;
        end else if (ce) begin
            done_q <= 1'b0;
            if (stop) begin
                run_q <= 1'b0;
            end else if (start) begin
                run_q <= 1'b1;
                acc_q <= PERIOD_PS[TGT_W-1:0];
                tgt_q <= target_ps;
            end else if (run_q) begin
                if (acc_q >= tgt_q) begin
                    run_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    acc_q <= acc_q + PERIOD_PS[TGT_W-1:0];
                end
            end
        end
    end

    assign busy = run_q;
    assign done = done_q;
endmodule // interval_timer
`default_nettype wire

// *** verilog/rfid_tx_timing.sv ***
/*
 * Transmit timing and options block of a proximity-card reader: AXI4-Lite
 * register file, bit-rate choice, parity generation and check, modulation
 * pulse length and the no-response timer with its interrupt.
 * Assumes a single clock, synchronous inputs and one outstanding access per
 * direction from the bus master.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rfid_tx_consts.svh"

// Notes on behaviour
// - rate field picks 106/212/424/848 kbps
// - split enable lets tx rate differ
// - tx parity odd, last byte even
// - rx check odd, last byte even
// - options clear on reset, disable, protocol write
// - zero pulse length uses protocol preset
// - nonzero N gives N times 73.7 ns
// - presets 2.36us, 1.4us, 737ns, 442ns
// - pulse length clears likewise
// - timer runs slot start to response
// - expiry raises interrupt and status flag
// - timeout is N times 37.76 us
// - no-response loads 0x0e likewise
module rfid_tx_timing
    import rfid_tx_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter logic [39:0] NO_REPLY_STEP_PS = `NO_REPLY_STEP_PS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic chip_en,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire tx_rate_e rx_rate,
    output tx_rate_e tx_rate,
    input wire byte_beat_s tx_byte,
    output logic tx_parity,
    input wire byte_beat_s rx_byte,
    input wire logic rx_parity,
    output logic rx_parity_err,
    input wire logic mod_pulse_req,
    output logic mod_pulse,
    input wire logic slot_start,
    input wire logic rx_sof_detect,
    output logic no_reply_wait,
    output logic irq
);
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_chk
        $error("rfid_tx_timing: ADDR_W must be 6..32");
    end

    function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        return a[ADDR_W-1:`ADDR_LSB] == (ADDR_W-`ADDR_LSB)'(idx);
    endfunction

    // odd parity unless the even choice applies
    function automatic logic par_bit(input logic [7:0] d, input logic even);
        return even ? ^d : ~^d;
    endfunction

    logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [7:0] proto_q, pulse_len_q, no_reply_q, status_q, mask_q;
    hr_options_s opt_q;
    tx_rate_e tx_rate_q;
    logic tx_parity_q, rx_err_q, irq_q;
    nr_state_e nr_state_q;
    logic wr_fire, wr_ok, proto_wr, soft_clr, wr_mapped;
    logic pulse_busy, nr_busy, nr_done;
    logic [39:0] pulse_tgt;
    logic [7:0] status_set, status_clr, rd_byte;
    logic rd_mapped;

    // write path: address and data are taken in either order
    assign awready = ce && !aw_held_q && !bvalid_q;
    assign wready = ce && !w_held_q && !bvalid_q;
    assign wr_fire = ce && aw_held_q && w_held_q && !bvalid_q;
    assign wr_ok = wr_fire && wstrb_q[0];
    assign wr_mapped = hits(awaddr_q, `IDX_PROTO_CTRL) || hits(awaddr_q, `IDX_HR_OPTIONS)
        || hits(awaddr_q, `IDX_PULSE_LEN) || hits(awaddr_q, `IDX_NO_REPLY)
        || hits(awaddr_q, `IDX_IRQ_STATUS) || hits(awaddr_q, `IDX_IRQ_MASK)
        || hits(awaddr_q, `IDX_BLOCK_STATE);
    assign proto_wr = wr_ok && hits(awaddr_q, `IDX_PROTO_CTRL);
    assign soft_clr = !chip_en || proto_wr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // read path: one cycle from address to data
    assign arready = ce && !rvalid_q;

    always_comb begin
        rd_byte = 8'h00;
        rd_mapped = 1'b1;
        if (hits(araddr, `IDX_PROTO_CTRL)) begin
            rd_byte = proto_q;
        end else if (hits(araddr, `IDX_HR_OPTIONS)) begin
            rd_byte = opt_q;
        end else if (hits(araddr, `IDX_PULSE_LEN)) begin
            rd_byte = pulse_len_q;
        end else if (hits(araddr, `IDX_NO_REPLY)) begin
            rd_byte = no_reply_q;
        end else if (hits(araddr, `IDX_IRQ_STATUS)) begin
            rd_byte = status_q;
        end else if (hits(araddr, `IDX_IRQ_MASK)) begin
            rd_byte = mask_q;
        end else if (hits(araddr, `IDX_BLOCK_STATE)) begin
            rd_byte = {4'h0, nr_busy, pulse_busy, tx_rate_q};
        end else begin
            rd_mapped = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid_q <= 1'b1;
                rdata_q <= {24'h000000, rd_byte};
                rresp_q <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rvalid_q && rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // preset registers; the protocol write wins over any other write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            proto_q <= `RST_PROTO_CTRL;
            opt_q <= `RST_HR_OPTIONS;
            pulse_len_q <= `RST_PULSE_LEN;
            no_reply_q <= `RST_NO_REPLY;
        end else if (ce) begin
            if (soft_clr) begin
                opt_q <= `RST_HR_OPTIONS;
                pulse_len_q <= `RST_PULSE_LEN;
                no_reply_q <= `RST_NO_REPLY;
                if (proto_wr) begin
                    proto_q <= wdata_q[7:0];
                end
            end else if (wr_ok) begin
                if (hits(awaddr_q, `IDX_HR_OPTIONS)) begin
                    opt_q <= {wdata_q[7:3], 3'b000};
                end
                if (hits(awaddr_q, `IDX_PULSE_LEN)) begin
                    pulse_len_q <= wdata_q[7:0];
                end
                if (hits(awaddr_q, `IDX_NO_REPLY)) begin
                    no_reply_q <= wdata_q[7:0];
                end
            end
        end
    end

    // interrupt status: hardware set wins over a write-one clear
    assign status_set = {7'h00, nr_done} << `IRQ_NO_REPLY_BIT;
    assign status_clr = (wr_ok && hits(awaddr_q, `IDX_IRQ_STATUS)) ? wdata_q[7:0] : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= `RST_IRQ;
            mask_q <= `RST_IRQ;
            irq_q <= 1'b0;
        end else if (ce) begin
            status_q <= (status_q & ~status_clr) | status_set;
            if (wr_ok && hits(awaddr_q, `IDX_IRQ_MASK)) begin
                mask_q <= wdata_q[7:0];
            end
            irq_q <= |(((status_q & ~status_clr) | status_set) & mask_q);
        end
    end

    assign irq = irq_q;

    // rate and parity
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_rate_q <= RATE_106;
            tx_parity_q <= 1'b0;
            rx_err_q <= 1'b0;
        end else if (ce) begin
            tx_rate_q <= opt_q.split_rate_enable ? opt_q.tx_rate : rx_rate;
            if (tx_byte.valid) begin
                tx_parity_q <= par_bit(tx_byte.data,
                    opt_q.tx_last_byte_even_parity && tx_byte.last);
            end
            if (rx_byte.valid) begin
                rx_err_q <= rx_parity != par_bit(rx_byte.data,
                    opt_q.rx_last_byte_even_parity && rx_byte.last);
            end
        end
    end

    assign tx_rate = tx_rate_q;
    assign tx_parity = tx_parity_q;
    assign rx_parity_err = rx_err_q;

    // modulation pulse length: override or protocol preset
    always_comb begin
        if (pulse_len_q != 8'h00) begin
            pulse_tgt = 40'(pulse_len_q) * `PULSE_STEP_PS;
        end else begin
            unique case (tx_rate_q)
                RATE_106: pulse_tgt = `PRESET_PS_106;
                RATE_212: pulse_tgt = `PRESET_PS_212;
                RATE_424: pulse_tgt = `PRESET_PS_424;
                RATE_848: pulse_tgt = `PRESET_PS_848;
            endcase
        end
    end

    // a request during a running pulse is ignored
    interval_timer #(
        .TGT_W(40),
        .PERIOD_PS(`CLK_PERIOD_PS)
    ) u_pulse (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .start(mod_pulse_req && !pulse_busy),
        .stop(1'b0),
        .target_ps(pulse_tgt),
        .busy(pulse_busy),
        .done()
    );

    assign mod_pulse = pulse_busy;

    // no-response timer; a zero setting never expires
    interval_timer #(
        .TGT_W(40),
        .PERIOD_PS(`CLK_PERIOD_PS)
    ) u_no_reply (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .start(slot_start && no_reply_q != 8'h00),
        .stop(rx_sof_detect),
        .target_ps(40'(no_reply_q) * NO_REPLY_STEP_PS),
        .busy(nr_busy),
        .done(nr_done)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nr_state_q <= NR_IDLE;
        end else if (ce) begin
            unique case (nr_state_q)
                NR_IDLE: if (slot_start && !rx_sof_detect && no_reply_q != 8'h00) begin
                    nr_state_q <= NR_WAIT;
                end
                NR_WAIT: if (rx_sof_detect || nr_done) begin
                    nr_state_q <= NR_IDLE;
                end
            endcase
        end
    end

    assign no_reply_wait = nr_state_q == NR_WAIT;

    a_opt_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && soft_clr |=> opt_q == `RST_HR_OPTIONS)
        else $error("options not cleared");

    a_pulse_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && soft_clr |=> pulse_len_q == `RST_PULSE_LEN)
        else $error("pulse length not cleared");

    a_noreply_preset: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && soft_clr |=> no_reply_q == `RST_NO_REPLY)
        else $error("no-response not preset");

    a_rate_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !opt_q.split_rate_enable |=> tx_rate_q == $past(rx_rate))
        else $error("tx rate not following rx rate");

    a_tx_parity: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && tx_byte.valid && tx_byte.last && opt_q.tx_last_byte_even_parity
        |=> tx_parity_q == ^$past(tx_byte.data))
        else $error("last byte not even parity");

    a_rx_parity: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && rx_byte.valid && !rx_byte.last && (rx_parity == ^rx_byte.data)
        |=> rx_err_q)
        else $error("odd parity error missed");

    a_pulse_preset: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && mod_pulse_req && !pulse_busy && pulse_len_q == 8'h00 && tx_rate_q == RATE_848
        |-> pulse_tgt == `PRESET_PS_848)
        else $error("preset pulse wrong");

    a_pulse_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && mod_pulse_req && !pulse_busy && pulse_len_q != 8'h00 |=> mod_pulse [*8])
        else $error("override pulse too short");

    a_noreply_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && nr_done |=> status_q[`IRQ_NO_REPLY_BIT] && (irq_q == mask_q[`IRQ_NO_REPLY_BIT]
            || |(status_q & mask_q)))
        else $error("no-response flag not set");

    a_noreply_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && rx_sof_detect |=> !nr_busy && !nr_done)
        else $error("timer ran past response");
endmodule // rfid_tx_timing
`default_nettype wire

// *** bench/host_bfm.sv ***
/*
 * Host side of the register bus: an AXI4-Lite master with one write and
 * one read task, called hierarchically by the testbench.
 * Assumes tasks are entered right after a rising edge of aclk.
 */
`timescale 1ns/1ps
`default_nettype none
module host_bfm (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // one edge before raising, so bready is never assigned twice in a step
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        r = 2'bxx;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // no cycle budget here: a hang is ended by the bench watchdog
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        r = 2'bxx;
        v = 'x;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                v = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule // host_bfm
`default_nettype wire

// *** bench/tb_top.sv ***
/*
 * Self-checking bench for the transmit timing block: register defaults and
 * presets, rate choice, parity, pulse length and no-response timer.
 * Assumes host_bfm for bus access; timer step shortened to 10 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rfid_tx_consts.svh"
module tb_top
    import rfid_tx_pkg::*;
;
    logic aclk, aresetn, chip_en, ce;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    tx_rate_e rx_rate, tx_rate;
    byte_beat_s tx_byte, rx_byte;
    logic rx_parity, tx_parity, rx_parity_err, mod_pulse_req, mod_pulse;
    logic slot_start, rx_sof_detect, no_reply_wait, irq;
    int bad_count, n_compared, r_i;
    longint ps_tab [4] = '{`PRESET_PS_106, `PRESET_PS_212, `PRESET_PS_424, `PRESET_PS_848};

    rfid_tx_timing #(.ADDR_W(8), .NO_REPLY_STEP_PS(40'd80000)) uut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .chip_en(chip_en),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .rx_rate(rx_rate), .tx_rate(tx_rate), .tx_byte(tx_byte),
        .tx_parity(tx_parity), .rx_byte(rx_byte), .rx_parity(rx_parity),
        .rx_parity_err(rx_parity_err), .mod_pulse_req(mod_pulse_req),
        .mod_pulse(mod_pulse), .slot_start(slot_start), .rx_sof_detect(rx_sof_detect),
        .no_reply_wait(no_reply_wait), .irq(irq));

    host_bfm host (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic test_done();
        if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
        logic [1:0] r;
        host.rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, re});
    endtask

    task automatic wrc(input logic [7:0] a, input logic [31:0] v, input logic [1:0] re);
        logic [1:0] r;
        host.wr(a, v, r);
        chk({30'h0, r}, {30'h0, re});
    endtask

    task automatic defaults();
        rdc(8'h0c, 32'h0, `RESP_OKAY);
        rdc(8'h18, 32'h0, `RESP_OKAY);
        rdc(8'h1c, 32'h0e, `RESP_OKAY);
    endtask

    task automatic dirty();
        wrc(8'h0c, 32'hff, `RESP_OKAY);
        wrc(8'h18, 32'h05, `RESP_OKAY);
        wrc(8'h1c, 32'h03, `RESP_OKAY);
    endtask

    // high-time of a level output after a one-cycle strobe, within +-2 cycles
    task automatic span(input bit tmr, input longint e);
        int c;
        c = 0;
        if (tmr) slot_start <= 1'b1;
        else mod_pulse_req <= 1'b1;
        @(posedge aclk);
        slot_start <= 1'b0;
        mod_pulse_req <= 1'b0;
        repeat (3000) begin
            @(posedge aclk);
            if (!(tmr ? no_reply_wait : mod_pulse)) break;
            c++;
        end
        chk((c >= e - 2 && c <= e + 2) ? 32'(e) : 32'(c), 32'(e));
    endtask

    function automatic longint cyc(input longint ps);
        return (ps + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
    endfunction

    task automatic par(input logic l, input logic p, input logic te, input logic re);
        tx_byte <= '{valid: 1'b1, last: l, data: 8'h01};
        rx_byte <= '{valid: 1'b1, last: l, data: 8'h03};
        rx_parity <= p;
        @(posedge aclk);
        tx_byte <= '0;
        rx_byte <= '0;
        repeat (2) @(posedge aclk);
        chk({31'h0, tx_parity}, {31'h0, te});
        chk({31'h0, rx_parity_err}, {31'h0, re});
    endtask

    initial begin
        aresetn = 1'b0;
        chip_en = 1'b1;
        ce = 1'b1;
        rx_rate = RATE_424;
        tx_byte = '0;
        rx_byte = '0;
        {rx_parity, mod_pulse_req, slot_start, rx_sof_detect} = '0;
        bad_count = 0;
        n_compared = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        defaults();
        rdc(8'h3c, 32'h0, `RESP_SLVERR);
        wrc(8'h3c, 32'h1, `RESP_SLVERR);
        dirty();
        rdc(8'h0c, 32'hf8, `RESP_OKAY);
        wrc(8'h04, 32'h01, `RESP_OKAY);
        rdc(8'h04, 32'h01, `RESP_OKAY);
        defaults();
        dirty();
        // clock enable low freezes state, so the disable is not seen
        ce <= 1'b0;
        chip_en <= 1'b0;
        @(posedge aclk);
        ce <= 1'b1;
        chip_en <= 1'b1;
        rdc(8'h0c, 32'hf8, `RESP_OKAY);
        @(posedge aclk);
        chip_en <= 1'b0;
        @(posedge aclk);
        chip_en <= 1'b1;
        defaults();
        rdc(8'h38, 32'h02, `RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({30'h0, tx_rate}, {30'h0, RATE_424});
        rx_rate <= RATE_212;
        repeat (2) @(posedge aclk);
        chk({30'h0, tx_rate}, {30'h0, RATE_212});
        for (r_i = 0; r_i < 4; r_i++) begin
            wrc(8'h0c, 32'h80 | (r_i << 5), `RESP_OKAY);
            repeat (2) @(posedge aclk);
            chk({30'h0, tx_rate}, 32'(r_i));
            span(1'b0, cyc(ps_tab[r_i]));
        end
        wrc(8'h18, 32'h01, `RESP_OKAY);
        span(1'b0, cyc(`PULSE_STEP_PS));
        wrc(8'h18, 32'h03, `RESP_OKAY);
        span(1'b0, cyc(3 * `PULSE_STEP_PS));
        wrc(8'h0c, 32'h18, `RESP_OKAY);
        par(1'b0, 1'b1, 1'b0, 1'b0);
        par(1'b1, 1'b1, 1'b1, 1'b1);
        par(1'b1, 1'b0, 1'b1, 1'b0);
        par(1'b0, 1'b0, 1'b0, 1'b1);
        wrc(8'h04, 32'h01, `RESP_OKAY);
        par(1'b1, 1'b1, 1'b0, 1'b0);
        wrc(8'h34, 32'h01, `RESP_OKAY);
        span(1'b1, 140);
        chk({31'h0, irq}, 32'h1);
        rdc(8'h30, 32'h1, `RESP_OKAY);
        wrc(8'h30, 32'h1, `RESP_OKAY);
        rdc(8'h30, 32'h0, `RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        wrc(8'h1c, 32'h03, `RESP_OKAY);
        wrc(8'h34, 32'h00, `RESP_OKAY);
        span(1'b1, 30);
        chk({31'h0, irq}, 32'h0);
        rdc(8'h30, 32'h1, `RESP_OKAY);
        wrc(8'h30, 32'h1, `RESP_OKAY);
        slot_start <= 1'b1;
        @(posedge aclk);
        slot_start <= 1'b0;
        repeat (5) @(posedge aclk);
        rx_sof_detect <= 1'b1;
        @(posedge aclk);
        rx_sof_detect <= 1'b0;
        repeat (40) @(posedge aclk);
        chk({31'h0, no_reply_wait}, 32'h0);
        rdc(8'h30, 32'h0, `RESP_OKAY);
        test_done();
    end

    // whole run is under two thousand cycles; this limit of 25000 cycles is far past that
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
endmodule // tb_top
`default_nettype wire
